// ### hdl/hgr_pkg.sv
// package: register map, encodings and timing constants of the glitch run control
`default_nettype none
package hgr_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;  // bit0 busy(ro), bit1 plugged(ro), write commands
   localparam logic [7:0] REG_GLITCH    = 8'h04;  // glitch step/count, cycle step/count
   localparam logic [7:0] REG_MODE      = 8'h08;  // glitch mode, ratio, trigger settings
   localparam logic [7:0] REG_FLAGS     = 8'h0C;  // read clears
   localparam logic [7:0] REG_GEN       = 8'h10;  // per-signal glitch enables
   localparam logic [7:0] REG_MON_SEL   = 8'h14;  // single signal select for query
   localparam logic [7:0] REG_MON_VAL   = 8'h18;  // query result
   localparam logic [7:0] REG_SWITCH    = 8'h1C;  // switch state readback
   // command bits in REG_CTRL writes
   localparam int CMD_PLUG   = 0;
   localparam int CMD_PULL   = 1;
   localparam int CMD_GONCE  = 2;
   localparam int CMD_GCYCLE = 3;
   localparam int CMD_GPRBS  = 4;
   localparam int CMD_GSTOP  = 5;
   // field positions
   localparam int FLD_BUSY = 0;
   localparam int FLD_PLUG = 1;
   localparam int FLD_REJ  = 2;
   localparam int FLD_GST  = 4;   // 2 bits sequencer state
   localparam int FLD_GSTEP = 0;  // 3 bits
   localparam int FLD_GCNT  = 8;  // 8 bits
   localparam int FLD_CSTEP = 16;
   localparam int FLD_CCNT  = 24;
   localparam int FLD_GMODE = 0;  // 2 bits
   localparam int FLD_RATIO = 4;  // 4 bits, ratio = 2^(v+1)
   localparam int FLD_TIMODE = 8; // 2 bits
   localparam int FLD_TITYPE = 10;
   localparam int FLD_TOMODE = 12;// 2 bits
   localparam int FLD_CMPL = 0;
   localparam int FLD_TRIG = 1;
   localparam int FLD_MON_ERR = 8;
   // number of switched signals and monitor points
   localparam int NUM_SIG = 32;
   localparam int NUM_MON = 18;   // 4 both sides (x2) + 10 drive only
   localparam logic [5:0] MON_SEL_GROUP = 6'h20; // codes at or above this name groups
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int STEP_NS = 50;
   localparam int STEP_CYC = (STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // 50ns rounds up, no int overflow
   localparam int PLUG_TIME_US = 100;  // switch sequencing time
   localparam int PLUG_CYC = PLUG_TIME_US * (CLK_HZ / 1_000_000);
   localparam int TRIG_OUT_CYC = 4;
   // reset values
   localparam logic [31:0] RST_GLITCH = 32'h0000_0000;
   localparam logic [3:0]  RST_RATIO  = 4'h0;
   typedef enum logic [1:0] {GM_ONCE = 2'b00, GM_CYCLE = 2'b01, GM_PRBS = 2'b10} hgr_gmode_t;
   typedef enum logic [1:0] {TM_OFF = 2'b00, TM_POWER = 2'b01, TM_GLITCH = 2'b10} hgr_tmode_t;
   typedef enum logic [1:0] {GS_IDLE = 2'b00, GS_ON = 2'b01, GS_OFF = 2'b10} hgr_gstate_t;
endpackage : hgr_pkg
`default_nettype wire

// ### hdl/hgr_run_control.sv
// top: hot-plug and glitch run control with AXI4-Lite registers
// How it works
// - random ratio field holds powers of two, 2 up to 65536.
// - one plug or pull command sequences every switch together.
// - plug while plugged or pull while pulled is refused, nothing switches.
// - busy bit in register 0 set from start until sequence ends.
// - plugged state readable in register 0.
// - once mode glitches step times count plus one clock.
// - cycle mode alternates glitch and release times until stopped.
// - random mode keeps glitching until stopped.
// - stop ends any running glitch sequence.
// - sequencer state is readable.
// - trigger input mode off, toggle plug state, or start glitch.
// - trigger input edge or level, type readable.
// - trigger output off, on hot swap, or on glitch.
// - completion and trigger flags latch, reading clears them.
// - stored glitch mode picks what the trigger starts.
// - trigger logic exists only when the trigger variant parameter is set.
// - reset and bus sidebands monitored both sides, others drive only.
// - value queries accept single signals and refuse group codes.
// - times are decade step 50ns..500ms times count 0..255.
// - ratio N below 65536 glitches about one slot in N.
// - each signal has its own enable; enabled ones glitch together.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module hgr_run_control
   import hgr_pkg::*;
#(
   parameter bit HAS_TRIGGER = 1'b1,
   parameter int PLUG_CYCLES = PLUG_CYC
)(
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                trig_in,
   output logic                     trig_out,
   input  wire logic [NUM_MON-1:0]  mon_in,
   output logic [NUM_SIG-1:0]       switch_closed
);
   // registers
   logic [31:0]        glitch_cfg;
   hgr_gmode_t         glitch_mode;
   logic [3:0]         random_glitch_ratio;
   hgr_tmode_t         trig_in_mode;
   logic               trig_in_level;
   hgr_tmode_t         trig_out_mode;
   logic [NUM_SIG-1:0] glitch_en;
   logic [5:0]         mon_sel;
   logic               mon_err;
   logic               plugged;
   logic               busy;
   logic               rejected;
   logic               cmpl_flag;
   logic               external_trig_flag;
   hgr_gstate_t        gstate;
   logic [31:0]        plug_cnt;
   logic [15:0]        lfsr;
   logic               slot_hit;
   logic               trig_q;
   logic [2:0]         tout_cnt;
   // bus handshake state
   logic               aw_held;
   logic               w_held;
   logic [7:0]         aw_addr;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic               wr_go;
   logic               rd_go;
   // command decode
   logic               cmd_plug;
   logic               cmd_pull;
   logic               cmd_gstart;
   hgr_gmode_t         cmd_gmode;
   logic               cmd_gstop;
   logic               trig_evt;
   logic               tmr_start;
   hgr_gmode_t         glitch_mode_run;
   logic               tmr_done;
   logic [2:0]         tmr_step;
   logic [7:0]         tmr_count;
   logic               plug_done;
   logic               glitch_done;
   logic [31:0]        next_rdata;

   // write address and data may arrive in either order
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // ready flags registered; one write and one read in flight
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:2] > REG_SWITCH[7:2]) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= (s_axi_araddr[7:2] > REG_SWITCH[7:2]) ? 2'h2 : 2'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
         REG_CTRL: begin
            next_rdata[FLD_BUSY]         = busy;
            next_rdata[FLD_PLUG]         = plugged;
            next_rdata[FLD_REJ]          = rejected;
            next_rdata[FLD_GST +: 2]     = gstate;
         end
         REG_GLITCH: next_rdata = glitch_cfg;
         REG_MODE: begin
            next_rdata[FLD_GMODE +: 2]   = glitch_mode;
            next_rdata[FLD_RATIO +: 4]   = random_glitch_ratio;
            if (HAS_TRIGGER) begin
               next_rdata[FLD_TIMODE +: 2] = trig_in_mode;
               next_rdata[FLD_TITYPE]      = trig_in_level;
               next_rdata[FLD_TOMODE +: 2] = trig_out_mode;
            end
         end
         REG_FLAGS: begin
            next_rdata[FLD_CMPL]         = cmpl_flag;
            next_rdata[FLD_TRIG]         = external_trig_flag;
         end
         REG_GEN:     next_rdata[NUM_SIG-1:0] = glitch_en;
         REG_MON_SEL: next_rdata[5:0]         = mon_sel;
         REG_MON_VAL: begin
            next_rdata[FLD_MON_ERR]      = mon_err;
            next_rdata[0]                = !mon_err && mon_in[mon_sel[4:0]];
         end
         REG_SWITCH:  next_rdata[NUM_SIG-1:0] = switch_closed;
         default:     next_rdata = 32'h0000_0000;
      endcase
   end

   // command strobes from writes to the control word
   assign cmd_plug   = wr_go && aw_addr == REG_CTRL && w_strb[0] && w_data[CMD_PLUG];
   assign cmd_pull   = wr_go && aw_addr == REG_CTRL && w_strb[0] && w_data[CMD_PULL];
   assign cmd_gstop  = wr_go && aw_addr == REG_CTRL && w_strb[0] && w_data[CMD_GSTOP];

   // trigger input: edge or level qualified, only in trigger variant
   assign trig_evt = HAS_TRIGGER && (trig_in_level ? trig_in : (trig_in && !trig_q));

   always_comb begin
      cmd_gstart = 1'b0;
      cmd_gmode  = glitch_mode;
      if (wr_go && aw_addr == REG_CTRL && w_strb[0] && !w_data[CMD_GSTOP]) begin
         if (w_data[CMD_GONCE]) begin
            cmd_gstart = 1'b1;
            cmd_gmode  = GM_ONCE;
         end else if (w_data[CMD_GCYCLE]) begin
            cmd_gstart = 1'b1;
            cmd_gmode  = GM_CYCLE;
         end else if (w_data[CMD_GPRBS]) begin
            cmd_gstart = 1'b1;
            cmd_gmode  = GM_PRBS;
         end
      end
      if (trig_evt && trig_in_mode == TM_GLITCH && gstate == GS_IDLE) begin
         cmd_gstart = 1'b1;
         cmd_gmode  = glitch_mode;
      end
   end

   // configuration registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         glitch_cfg          <= RST_GLITCH;
         glitch_mode         <= GM_ONCE;
         random_glitch_ratio <= RST_RATIO;
         trig_in_mode        <= TM_OFF;
         trig_in_level       <= 1'b0;
         trig_out_mode       <= TM_OFF;
         glitch_en           <= '0;
         mon_sel             <= 6'h00;
      end else if (wr_go) begin
         if (aw_addr == REG_GLITCH) begin
            for (int b = 0; b < 4; b++) begin
               if (w_strb[b]) glitch_cfg[8*b +: 8] <= w_data[8*b +: 8];
            end
         end
         if (aw_addr == REG_MODE && w_strb[0]) begin
            if (w_data[FLD_GMODE +: 2] != 2'b11) glitch_mode <= hgr_gmode_t'(w_data[FLD_GMODE +: 2]);
            random_glitch_ratio <= w_data[FLD_RATIO +: 4];
         end
         if (aw_addr == REG_MODE && w_strb[1] && HAS_TRIGGER) begin
            if (w_data[FLD_TIMODE +: 2] != 2'b11) trig_in_mode <= hgr_tmode_t'(w_data[FLD_TIMODE +: 2]);
            trig_in_level <= w_data[FLD_TITYPE];
            if (w_data[FLD_TOMODE +: 2] != 2'b11) trig_out_mode <= hgr_tmode_t'(w_data[FLD_TOMODE +: 2]);
         end
         if (aw_addr == REG_GEN) glitch_en <= w_data[NUM_SIG-1:0];
         if (aw_addr == REG_MON_SEL && w_strb[0]) mon_sel <= w_data[5:0];
      end
   end

   // group codes and out-of-range selectors flag an error instead of a value
   assign mon_err = (mon_sel >= MON_SEL_GROUP) || (mon_sel[4:0] >= 5'(NUM_MON));

   // hot-plug sequencer; refused requests only set the rejected bit
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         plugged  <= 1'b0;
         busy     <= 1'b0;
         rejected <= 1'b0;
         plug_cnt <= 32'h0000_0000;
      end else begin
         if (!busy && (cmd_plug || (trig_evt && trig_in_mode == TM_POWER && !plugged))) begin
            if (plugged) begin
               rejected <= 1'b1;
            end else begin
               busy     <= 1'b1;
               plugged  <= 1'b1;
               rejected <= 1'b0;
               plug_cnt <= 32'(PLUG_CYCLES);
            end
         end else if (!busy && (cmd_pull || (trig_evt && trig_in_mode == TM_POWER && plugged))) begin
            if (!plugged) begin
               rejected <= 1'b1;
            end else begin
               busy     <= 1'b1;
               plugged  <= 1'b0;
               rejected <= 1'b0;
               plug_cnt <= 32'(PLUG_CYCLES);
            end
         end else if (busy) begin
            plug_cnt <= 32'(plug_cnt - 32'h1);
            if (plug_cnt <= 32'h1) busy <= 1'b0;
         end
      end
   end
   assign plug_done = busy && plug_cnt <= 32'h1;

   // glitch sequencer: on phase uses glitch time, off phase cycle time in cycle mode and glitch time in random mode
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gstate <= GS_IDLE;
      end else begin
         unique case (gstate)
            GS_IDLE: if (cmd_gstart) gstate <= GS_ON;
            GS_ON: begin
               if (cmd_gstop) gstate <= GS_IDLE;
               else if (tmr_done && glitch_mode_run == GM_ONCE) gstate <= GS_IDLE;
               else if (tmr_done) gstate <= GS_OFF;
            end
            GS_OFF: begin
               if (cmd_gstop) gstate <= GS_IDLE;
               else if (tmr_done && glitch_mode_run == GM_CYCLE) gstate <= GS_ON;
               else if (tmr_done) gstate <= GS_ON;
            end
            default: gstate <= GS_IDLE;
         endcase
      end
   end

   // run mode latched at start so a mode write does not disturb a sequence
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) glitch_mode_run <= GM_ONCE;
      else if (gstate == GS_IDLE && cmd_gstart) glitch_mode_run <= cmd_gmode;
   end

   // random mode slots last one glitch time each; the off phase of a slot is idle
   assign tmr_start = (gstate == GS_IDLE && cmd_gstart) || (gstate != GS_IDLE && tmr_done && !cmd_gstop
                      && !(gstate == GS_ON && glitch_mode_run == GM_ONCE));
   always_comb begin
      if (glitch_mode_run == GM_CYCLE && ((gstate == GS_ON && tmr_done) || (gstate == GS_OFF && !tmr_done))) begin
         tmr_step  = glitch_cfg[FLD_CSTEP +: 3];
         tmr_count = glitch_cfg[FLD_CCNT +: 8];
      end else begin
         tmr_step  = glitch_cfg[FLD_GSTEP +: 3];
         tmr_count = glitch_cfg[FLD_GCNT +: 8];
      end
   end
   assign glitch_done = gstate == GS_ON && (cmd_gstop || (tmr_done && glitch_mode_run == GM_ONCE));

   hgr_step_timer u_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (tmr_start),
      .abort    (cmd_gstop),
      .step_sel (tmr_step),
      .count    (tmr_count),
      .running  (),
      .done     (tmr_done)
   );

   // lfsr x^16+x^14+x^13+x^11, drawn once per slot; hit when low ratio+1 bits are zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lfsr     <= 16'hACE1;
         slot_hit <= 1'b1;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         if (tmr_start && (gstate == GS_IDLE ? cmd_gmode : glitch_mode_run) == GM_PRBS) begin
            slot_hit <= ((lfsr & 16'((32'h2 << random_glitch_ratio) - 32'h1)) == 16'h0000);
         end
      end
   end

   // switch drive: all closed when plugged, enabled ones opened while glitching
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         switch_closed <= '0;
      end else begin
         for (int s = 0; s < NUM_SIG; s++) begin
            switch_closed[s] <= plugged && !(glitch_en[s] && gstate == GS_ON
                                && (glitch_mode_run != GM_PRBS || slot_hit));
         end
      end
   end

   // sticky flags: a set in the read cycle wins over the clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmpl_flag          <= 1'b0;
         external_trig_flag <= 1'b0;
         trig_q             <= 1'b0;
      end else begin
         trig_q <= trig_in;
         if (plug_done || glitch_done) cmpl_flag <= 1'b1;
         else if (rd_go && s_axi_araddr == REG_FLAGS) cmpl_flag <= 1'b0;
         if (trig_evt) external_trig_flag <= 1'b1;
         else if (rd_go && s_axi_araddr == REG_FLAGS) external_trig_flag <= 1'b0;
      end
   end

   // trigger out pulse stretched to a few cycles
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tout_cnt <= 3'h0;
         trig_out <= 1'b0;
      end else begin
         if (HAS_TRIGGER && ((trig_out_mode == TM_POWER && plug_done)
             || (trig_out_mode == TM_GLITCH && gstate == GS_IDLE && cmd_gstart))) begin
            tout_cnt <= 3'(TRIG_OUT_CYC);
         end else if (tout_cnt != 3'h0) begin
            tout_cnt <= 3'(tout_cnt - 3'h1);
         end
         trig_out <= tout_cnt != 3'h0;
      end
   end
endmodule : hgr_run_control
`default_nettype wire

// ### hdl/hgr_step_timer.sv
// step timer: counts count x decade step, pulses done at the end
`default_nettype none
module hgr_step_timer
   import hgr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic [2:0] step_sel,
   input  wire logic [7:0] count,
   output logic            running,
   output logic            done
);
   logic [31:0] tick_cnt;
   logic [7:0]  left;
   logic [31:0] step_len;
   logic [63:0] scaled;

   // decade steps 50ns .. 500ms, rounded once after scaling so the error does not grow
   always_comb begin
      scaled = 64'(STEP_NS * (CLK_HZ / 1_000_000));
      for (int i = 0; i < 7; i++) begin
         if (3'(i) < step_sel) begin
            scaled = 64'(scaled * 10);
         end
      end
      step_len = 32'((scaled + 64'h3E7) / 64'h3E8);
   end

   // a zero count finishes on the next edge so sequences never hang
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         running  <= 1'b0;
         done     <= 1'b0;
         tick_cnt <= 32'h0000_0000;
         left     <= 8'h00;
      end else begin
         done <= 1'b0;
         if (abort) begin
            running <= 1'b0;
         end else if (start) begin
            running  <= (count != 8'h00);
            done     <= (count == 8'h00);
            left     <= count;
            tick_cnt <= 32'h0000_0000;
         end else if (running) begin
            if (tick_cnt + 32'h1 >= step_len) begin
               tick_cnt <= 32'h0000_0000;
               if (left == 8'h01) begin
                  running <= 1'b0;
                  done    <= 1'b1;
               end
               left <= 8'(left - 8'h01);
            end else begin
               tick_cnt <= 32'(tick_cnt + 32'h1);
            end
         end
      end
   end
endmodule : hgr_step_timer
`default_nettype wire

// ### testbench/hgr_host_stub.sv
// host stub: external trigger pulses and monitor-point levels
`default_nettype none
module hgr_host_stub
   import hgr_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               trig_req,
   output logic                    trig_in,
   output logic [NUM_MON-1:0]      mon_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] hold_cnt = 2'h0;
   // pulse held three cycles so edge and level readings both see it
   always_ff @(posedge core_clk) begin
      if (trig_req) hold_cnt <= 2'h3;
      else if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
   end
   assign trig_in = (hold_cnt != 2'h0);
   assign mon_in = 18'h2AAAA;
endmodule : hgr_host_stub
`default_nettype wire

// ### testbench/hgr_rc_monitor.sv
// checker: bus answers and trigger-out timing at the run control ports
`default_nettype none
module hgr_rc_monitor (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        trig_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // request acceptance steps
   sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence wr_take; s_axi_awvalid && s_axi_awready; endsequence
   read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
   write_answer_a: assert property (wr_take |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
   read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
   write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write twice");
   ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken early");
   read_code_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad rresp");
   trig_pulse_a: assert property ($rose(trig_out) |-> trig_out[*4]) else $error("trig out short");
endmodule : hgr_rc_monitor
bind hgr_run_control hgr_rc_monitor mon_u (.core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .trig_out);
`default_nettype wire

// ### testbench/hotswap_glitch_run_control_tb.sv
// testbench: register-level tests of the glitch run control
`default_nettype none
module hotswap_glitch_run_control_tb;
   import hgr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = '0, sys_rst = '1, trig_req = '0, seen_out = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trig_in, trig_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [2:0] hs;
   logic [NUM_MON-1:0] mon_in;
   logic [NUM_SIG-1:0] switch_closed;
   int miscompares = 0, tests_run = 0, cyc = 0;
   always #20 core_clk = ~core_clk;
   // long enough plug time that busy is still seen after a write answer
   hgr_run_control #(.PLUG_CYCLES(40)) dut_u (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .trig_in, .trig_out, .mon_in, .switch_closed);
   hgr_host_stub host_u (.core_clk, .trig_req, .trig_in, .mon_in);
   task automatic give_verdict;
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // handshakes judged at the falling edge, where ready is settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge core_clk);
         hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
         @(posedge core_clk);
         if (hs[2]) s_axi_awvalid <= 1'b0;
         if (hs[1]) s_axi_wvalid <= 1'b0;
      end while (!hs[0]);
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge core_clk);
         hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, 1'b0};
         v = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge core_clk);
         if (hs[2]) s_axi_arvalid <= 1'b0;
      end while (!hs[1]);
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask : rd
   // hang guard and trigger-out watch
   always @(posedge core_clk) begin
      cyc++;
      if (trig_out === 1'b1) seen_out <= 1'b1;
      if (cyc == 60000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(REG_CTRL);
      chk("ctrl_reset", 32'h0, v & 32'h0000_0037);
      wr(REG_CTRL, 32'h0000_0002);
      rd(REG_CTRL);
      chk("pull_refused", 32'h0000_0004, v & 32'h0000_0007);
      wr(REG_CTRL, 32'h0000_0001);
      rd(REG_CTRL);
      chk("busy_set", 32'h0000_0001, v & 32'h0000_0001);
      do rd(REG_CTRL); while (v[FLD_BUSY] !== 1'b0);
      chk("plugged", 32'h0000_0002, v & 32'h0000_0003);
      chk("all_closed", 32'hFFFF_FFFF, switch_closed);
      rd(REG_FLAGS);
      chk("done_flag", 32'h0000_0001, v & 32'h0000_0001);
      rd(REG_FLAGS);
      chk("flag_clear", 32'h0, v & 32'h0000_0003);
      rd(8'h40);
      chk("bad_addr", 32'h0000_0002, {30'h0, rr} | v);
      wr(REG_GEN, 32'h0000_00FF);
      wr(REG_GLITCH, 32'h1400_C800);
      wr(REG_CTRL, 32'h0000_0004);
      rd(REG_CTRL);
      chk("once_on", 32'h0000_0010, v & 32'h0000_0030);
      chk("only_enabled", 32'hFFFF_FF00, switch_closed);
      do rd(REG_CTRL); while (v[5:4] !== 2'h0);
      chk("once_over", 32'hFFFF_FFFF, switch_closed);
      wr(REG_GLITCH, 32'h1400_1400);
      wr(REG_CTRL, 32'h0000_0008);
      do rd(REG_CTRL); while (v[5:4] !== 2'h2);
      chk("cycle_release", 32'hFFFF_FFFF, switch_closed);
      wr(REG_CTRL, 32'h0000_0020);
      rd(REG_CTRL);
      chk("cycle_stop", 32'h0, v & 32'h0000_0030);
      wr(REG_MODE, 32'h0000_11F2);
      rd(REG_MODE);
      chk("mode_back", 32'h0000_11F2, v & 32'h0000_37F3);
      wr(REG_CTRL, 32'h0000_0010);
      rd(REG_CTRL);
      chk("prbs_run", 32'h1, {31'h0, v[5:4] != 2'h0});
      wr(REG_CTRL, 32'h0000_0020);
      rd(REG_CTRL);
      chk("prbs_stop", 32'h0, v & 32'h0000_0030);
      rd(REG_FLAGS);
      trig_req <= 1'b1;
      @(posedge core_clk);
      trig_req <= 1'b0;
      do rd(REG_CTRL); while (v[1:0] !== 2'h0);
      chk("trig_pull", 32'h0, switch_closed);
      chk("trig_out", 32'h1, {31'h0, seen_out});
      rd(REG_FLAGS);
      chk("trig_flags", 32'h0000_0003, v & 32'h0000_0003);
      wr(REG_MON_SEL, 32'h0000_0020);
      rd(REG_MON_VAL);
      chk("group_err", 32'h0000_0100, v & 32'h0000_0100);
      wr(REG_MON_SEL, 32'h0000_0003);
      rd(REG_MON_VAL);
      chk("mon_value", 32'h0000_0001, v & 32'h0000_0101);
      give_verdict;
   end
endmodule : hotswap_glitch_run_control_tb
`default_nettype wire
